/* hw/nand_host_pkg.sv */
package nand_host_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and flash timing
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned T_WB_NS       = 100;
  // Wait before ready/busy is trusted, rounded up
  localparam int unsigned WB_CYC =
    (T_WB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon register map, byte offsets
  localparam int unsigned ADDR_W     = 5;
  localparam logic [4:0]  OFS_CMD    = 5'h00;
  localparam logic [4:0]  OFS_ROW    = 5'h04;
  localparam logic [4:0]  OFS_RESULT = 5'h08;
  localparam logic [4:0]  OFS_CFG    = 5'h0c;
  localparam logic [4:0]  OFS_ECC    = 5'h10;

  // Result register fields
  localparam int unsigned RES_MAKER   = 8;
  localparam int unsigned RES_DEVICE  = 16;
  localparam int unsigned RES_BAD     = 24;
  localparam int unsigned RES_FAIL    = 25;
  localparam int unsigned RES_CHECKED = 26;
  localparam int unsigned RES_RB      = 27;
  // ECC data register: byte in [7:0], clear in bit 8
  localparam int unsigned ECC_CLR_BIT = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Status byte layout
  localparam int unsigned WP_BIT    = 7;
  localparam int unsigned IDLE_BIT  = 6;
  localparam int unsigned FAIL_BIT  = 0;
  localparam logic [7:0]  STAT_KEEP = 8'hc1;
  localparam logic [7:0]  STAT_RSVD = 8'h3e;

  ////////////////////////////////////////////////////////////////////////////
  // Command bytes and addresses
  localparam logic [7:0]  CMD_SIG        = 8'h90;
  localparam logic [7:0]  CMD_READ_SPARE = 8'h50;
  localparam logic [7:0]  SIG_ADDR       = 8'h00;
  localparam logic [7:0]  MARKER_COL     = 8'h05;
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;
  localparam int unsigned PAGE_BITS      = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Error correction sizes
  localparam int unsigned ECC_LP_W   = 16;
  localparam int unsigned ECC_CP_W   = 6;
  localparam int unsigned ECC_IDX_W  = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Operations and sequencer states
  typedef enum logic [1:0] {
    OP_RESET  = 2'h0,
    OP_STATUS = 2'h1,
    OP_SIG    = 2'h2,
    OP_MARK   = 2'h3
  } op_t;

  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_CMD_SET = 4'h1,
    S_CMD_STB = 4'h2,
    S_HOLD    = 4'h3,
    S_ADR_SET = 4'h4,
    S_ADR_STB = 4'h5,
    S_WB      = 4'h6,
    S_BUSY    = 4'h7,
    S_RD_STB  = 4'h8,
    S_RD_HOLD = 4'h9,
    S_DONE    = 4'ha
  } state_t;

endpackage

/* hw/ecc_accum.sv */
`timescale 1ns/1ps
module ecc_accum
  import nand_host_pkg::*;
(
  // System
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // Byte feed
  input  wire logic                     clr,
  input  wire logic                     vld,
  input  wire logic [7:0]               din,
  // Check bits
  output logic [ECC_LP_W+ECC_CP_W-1:0]  ecc
);

  logic [ECC_LP_W-1:0]  lp_q, lp_d;
  logic [ECC_CP_W-1:0]  cp_q, cp_d;
  logic [ECC_IDX_W-1:0] idx_q, idx_d;
  logic                 par;

  // Parity of the bits whose index has bit k equal to hi
  function automatic logic col_par(input logic [7:0] b, input int k,
                                   input logic hi);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i[k] == hi) begin
        r = r ^ b[i];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Line parity by byte index, column parity by bit index
  always_comb begin
    lp_d  = lp_q;
    cp_d  = cp_q;
    idx_d = idx_q;
    par   = ^din;
    if (clr) begin
      lp_d  = '0;
      cp_d  = '0;
      idx_d = '0;
    end else if (vld) begin
      for (int k = 0; k < ECC_IDX_W; k++) begin
        if (idx_q[k]) begin
          lp_d[2*k+1] = lp_d[2*k+1] ^ par;
        end else begin
          lp_d[2*k] = lp_d[2*k] ^ par;
        end
      end
      for (int k = 0; k < ECC_CP_W / 2; k++) begin
        cp_d[2*k]   = cp_q[2*k] ^ col_par(din, k, 1'b0);
        cp_d[2*k+1] = cp_q[2*k+1] ^ col_par(din, k, 1'b1);
      end
      // Wraps after one 2048-bit block; software clears per block
      idx_d = idx_q + 8'h01;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lp_q  <= '0;
      cp_q  <= '0;
      idx_q <= '0;
    end else begin
      lp_q  <= lp_d;
      cp_q  <= cp_d;
      idx_q <= idx_d;
    end
  end

  assign ecc = {lp_q, cp_q};

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  ecc_clear_a: assert property (clr |=> ecc == '0)
    else $error("ecc not cleared");
  // An odd byte flips exactly one bit of the first line-parity pair
  ecc_flip_a: assert property (
    (vld && !clr && ^din)
      |=> (lp_q[1] ^ lp_q[0]) != $past(lp_q[1] ^ lp_q[0]))
    else $error("odd byte did not flip line parity");

endmodule // ecc_accum

/* hw/nand_host.sv */
`timescale 1ns/1ps
// Operation
// - Status mode persists; host reissues a read command afterwards.
// - Status bits 1 to 5 are reserved; host ignores them.
// - Signature read: command byte then one zero address cycle.
// - Block bad if sixth spare byte of first page not all ones.
// - Host reads bad-block markers before any erase.
// - Program or erase status error marks block newly bad; host only reports status bit 0 as the fail flag.
// - Host provides 22 check bits per 2048 data bits.
module nand_host
  import nand_host_pkg::*;
#(
  parameter logic [7:0]  CMD_RESET  = 8'hff,
  parameter logic [7:0]  CMD_STATUS = 8'h70,
  parameter int unsigned DIV_CYCLES = 4
)(
  // System
  input  wire logic              mclk,
  input  wire logic              rst,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // Flash pins
  output logic                   cle,
  output logic                   ale,
  output logic                   ce_n,
  output logic                   we_n,
  output logic                   re_n,
  output logic                   wp_n,
  output logic      [7:0]        io_out,
  output logic                   io_oe,
  input  wire logic [7:0]        io_in,
  input  wire logic              rb
);

  ////////////////////////////////////////////////////////////////////////////
  // Strobe-rate divider
  logic [7:0] div_q, div_d;
  logic       tick_q, tick_d;

  always_comb begin
    tick_d = (div_q == 8'(DIV_CYCLES - 1));
    div_d  = tick_d ? 8'h00 : div_q + 8'h01;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then a one-cycle answer
  logic        wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [23:0] row_q, row_d;
  logic        allow_q, allow_d;
  logic        wr_fire, start, ecc_clr, ecc_vld;
  logic [21:0] ecc_val;
  state_t      st_q, st_d;
  logic [7:0]  status_q, maker_q, device_q;
  logic        bad_q, fail_q, checked_q;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [4:0] ofs);
    return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Writes act at the edge where waitrequest is seen low
  assign wr_fire = write && !wait_q;
  assign start   = wr_fire && hit(address, OFS_CMD) && byteenable[0]
                   && st_q == S_IDLE;
  assign ecc_vld = wr_fire && hit(address, OFS_ECC) && byteenable[0];
  assign ecc_clr = wr_fire && hit(address, OFS_ECC) && byteenable[1]
                   && writedata[ECC_CLR_BIT];

  always_comb begin
    wait_d  = !((read || write) && wait_q);
    rdata_d = rdata_q;
    row_d   = row_q;
    allow_d = allow_q;
    if (read && wait_q) begin
      rdata_d = '0;
      if (hit(address, OFS_CMD)) begin
        rdata_d[0] = st_q != S_IDLE;
      end else if (hit(address, OFS_ROW)) begin
        rdata_d[23:0] = row_q;
      end else if (hit(address, OFS_RESULT)) begin
        rdata_d = {4'h0, rb, checked_q, fail_q, bad_q,
                   device_q, maker_q, status_q};
      end else if (hit(address, OFS_CFG)) begin
        rdata_d[0] = allow_q;
      end else if (hit(address, OFS_ECC)) begin
        rdata_d[21:0] = ecc_val;
      end
    end
    if (wr_fire && hit(address, OFS_ROW)) begin
      row_d = 24'(merge({8'h00, row_q}, writedata, byteenable));
    end
    if (wr_fire && hit(address, OFS_CFG) && byteenable[0]) begin
      allow_d = writedata[0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
      row_q   <= '0;
      allow_q <= 1'b0;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      row_q   <= row_d;
      allow_q <= allow_d;
    end
  end

  assign waitrequest = wait_q;
  assign readdata    = rdata_q;

  ecc_accum u_ecc (
    .mclk (mclk),
    .rst  (rst),
    .clr  (ecc_clr),
    .vld  (ecc_vld),
    .din  (writedata[7:0]),
    .ecc  (ecc_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flash pin sequencer
  op_t        op_q, op_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] wb_q, wb_d;
  logic [7:0] status_d, maker_d, device_d, io_out_d;
  logic       bad_d, fail_d, checked_d;
  logic       cle_d, ale_d, ce_n_d, we_n_d, re_n_d, io_oe_d;
  logic [2:0] naddr, nread;
  logic       need_wait;

  // Per-operation shape
  always_comb begin
    case (op_q)
      OP_RESET:  begin naddr = 3'd0; nread = 3'd0; need_wait = 1'b1; end
      OP_STATUS: begin naddr = 3'd0; nread = 3'd1; need_wait = 1'b0; end
      OP_SIG:    begin naddr = 3'd1; nread = 3'd2; need_wait = 1'b0; end
      default:   begin naddr = 3'd4; nread = 3'd1; need_wait = 1'b1; end
    endcase
  end

  always_comb begin
    st_d = st_q;       op_d = op_q;       idx_d = idx_q;     wb_d = wb_q;
    cle_d = cle;       ale_d = ale;       ce_n_d = ce_n;     we_n_d = we_n;
    re_n_d = re_n;     io_out_d = io_out; io_oe_d = io_oe;
    status_d = status_q; maker_d = maker_q; device_d = device_q;
    bad_d = bad_q;     fail_d = fail_q;   checked_d = checked_q;
    case (st_q)
      S_IDLE: if (start) begin
        op_d     = op_t'(writedata[1:0]);
        idx_d    = 3'd0;
        ce_n_d   = 1'b0;
        cle_d    = 1'b1;
        io_oe_d  = 1'b1;
        case (op_t'(writedata[1:0]))
          OP_RESET:  io_out_d = CMD_RESET;
          OP_STATUS: io_out_d = CMD_STATUS;
          OP_SIG:    io_out_d = CMD_SIG;
          default:   io_out_d = CMD_READ_SPARE;
        endcase
        st_d = S_CMD_SET;
      end
      S_CMD_SET: if (tick_q) begin
        we_n_d = 1'b0;
        st_d   = S_CMD_STB;
      end
      S_CMD_STB, S_ADR_STB: if (tick_q) begin
        // Latch edge; address index advances after each address byte
        we_n_d = 1'b1;
        if (st_q == S_ADR_STB) begin
          idx_d = idx_q + 3'd1;
        end
        st_d = S_HOLD;
      end
      S_HOLD: if (tick_q) begin
        cle_d = 1'b0;
        ale_d = 1'b0;
        // Index counts to naddr (four for the marker read), so the last address cycle ends the phase
        if (st_q == S_HOLD && idx_q < naddr
            && !(op_q != OP_MARK && idx_q != 3'd0)) begin
          ale_d = 1'b1;
          st_d  = S_ADR_SET;
          case (idx_q)
            3'd0: io_out_d = (op_q == OP_SIG) ? SIG_ADDR
                                              : MARKER_COL;
            // First page of the block only
            3'd1: io_out_d = {row_q[7:PAGE_BITS],
                              PAGE_BITS'(0)};
            3'd2: io_out_d = row_q[15:8];
            default: io_out_d = row_q[23:16];
          endcase
        end else begin
          io_oe_d = 1'b0;
          idx_d   = 3'd0;
          wb_d    = 8'(WB_CYC);
          if (need_wait) begin
            st_d = S_WB;
          end else begin
            re_n_d = 1'b0;
            st_d   = S_RD_STB;
          end
        end
      end
      S_ADR_SET: if (tick_q) begin
        we_n_d = 1'b0;
        st_d   = S_ADR_STB;
      end
      S_WB: begin
        wb_d = wb_q - 8'h01;
        if (wb_q == 8'h00) begin
          st_d = S_BUSY;
        end
      end
      // Ready/busy stays low for the reset or page-load time
      S_BUSY: if (rb) begin
        if (nread == 3'd0) begin
          st_d = S_DONE;
        end else begin
          re_n_d = 1'b0;
          st_d   = S_RD_STB;
        end
      end
      S_RD_STB: if (tick_q) begin
        re_n_d = 1'b1;
        st_d   = S_RD_HOLD;
        case (op_q)
          // Reserved bits dropped; bits 7, 6, 0 kept live
          OP_STATUS: begin
            status_d = io_in & STAT_KEEP;
            fail_d   = io_in[FAIL_BIT];
          end
          OP_SIG: if (idx_q == 3'd0) begin
            maker_d  = io_in;
          end else begin
            device_d = io_in;
          end
          // Anything but all ones marks a bad block
          OP_MARK: bad_d = io_in != ERASED_BYTE;
          default: ;
        endcase
      end
      S_RD_HOLD: if (tick_q) begin
        idx_d = idx_q + 3'd1;
        if (idx_q + 3'd1 < nread) begin
          re_n_d = 1'b0;
          st_d   = S_RD_STB;
        end else begin
          st_d = S_DONE;
        end
      end
      S_DONE: begin
        ce_n_d = 1'b1;
        if (op_q == OP_MARK) begin
          checked_d = 1'b1;
        end
        st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= S_IDLE;      op_q <= OP_RESET;   idx_q <= '0;  wb_q <= '0;
      cle <= 1'b0;         ale <= 1'b0;        ce_n <= 1'b1; we_n <= 1'b1;
      re_n <= 1'b1;        io_out <= '0;       io_oe <= 1'b0;
      status_q <= '0;      maker_q <= '0;      device_q <= '0;
      bad_q <= 1'b0;       fail_q <= 1'b0;     checked_q <= 1'b0;
      wp_n <= 1'b0;
    end else begin
      st_q <= st_d;        op_q <= op_d;       idx_q <= idx_d; wb_q <= wb_d;
      cle <= cle_d;        ale <= ale_d;       ce_n <= ce_n_d; we_n <= we_n_d;
      re_n <= re_n_d;      io_out <= io_out_d; io_oe <= io_oe_d;
      status_q <= status_d; maker_q <= maker_d; device_q <= device_d;
      bad_q <= bad_d;      fail_q <= fail_d;   checked_q <= checked_d;
      // Protected until the markers have been read once and the config allow bit is set
      wp_n <= allow_q && checked_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sig_cmd_byte_a: assert property (
    (st_q == S_CMD_STB && op_q == OP_SIG) |-> cle && io_out == CMD_SIG)
    else $error("signature command byte wrong");
  sig_addr_zero_a: assert property (
    (st_q == S_ADR_STB && op_q == OP_SIG)
      |-> ale && !we_n && io_out == SIG_ADDR && idx_q == 3'd0)
    else $error("signature address not zero");
  reset_code_a: assert property (
    (st_q == S_CMD_STB && op_q == OP_RESET) |-> io_out == CMD_RESET)
    else $error("reset code wrong");
  status_mask_a: assert property ((status_q & STAT_RSVD) == 8'h00)
    else $error("reserved status bits kept");
  mark_verdict_a: assert property (
    (st_q == S_RD_STB && tick_q && op_q == OP_MARK)
      |=> bad_q == ($past(io_in) != ERASED_BYTE))
    else $error("bad block verdict wrong");
  wp_guard_a: assert property (wp_n |-> checked_q && $past(allow_q))
    else $error("unprotected before marker scan");
  fail_copy_a: assert property (
    (st_q == S_RD_STB && tick_q && op_q == OP_STATUS)
      |=> fail_q == $past(io_in[FAIL_BIT]))
    else $error("fail flag not taken from status");
  mark_cmd_a: assert property (
    (st_q == S_CMD_STB && op_q == OP_MARK) |-> io_out == CMD_READ_SPARE)
    else $error("marker read lacks read command");
  bus_ack_a: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");

endmodule // nand_host

/* tb/flash_model.sv */
`timescale 1ns/1ps
module flash_model
  import nand_host_pkg::*;
#(
  parameter logic [7:0] CODE_RESET  = 8'hff,
  parameter logic [7:0] CODE_STATUS = 8'h70,
  parameter logic [7:0] MAKER_ID    = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEVICE_ID   = 8'ha5, // Arbitrary value
  parameter int         RST_NS      = 2000
)(
  // Host pins
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       ce_n,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] io_out,
  // Answers
  output logic      [7:0] io_in,
  output logic            rb,
  // Scenario knobs
  input  wire logic       fail_in,
  input  wire logic [7:0] marker_byte
);
  logic [1:0] mode_q;
  logic       rst_state;
  logic       busy;
  logic [7:0] col;
  logic [7:0] last;
  logic [7:0] val;
  int         n_rd;
  int         n_adr;
  int         n_resets;

  ////////////////////////////////////////////////////////////////////////////
  // Power-up: ready, main area pointer
  initial begin
    rb = 1'b1;
    busy = 1'b0;
    rst_state = 1'b0;
    mode_q = 2'd0;
    n_rd = 0;
    n_adr = 0;
    n_resets = 0;
    last = 8'h00;
    col = 8'h00;
  end

  // Commands and addresses latch on the write strobe rise
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      n_adr = 0;
      if (io_out === CODE_RESET) begin
        mode_q = 2'd0;
        if (!rst_state) begin
          rst_state = 1'b1;
          n_resets++;
          busy = 1'b1;
          rb = 1'b0;
          rb <= #(RST_NS) 1'b1;
          busy <= #(RST_NS) 1'b0;
        end
      end else begin
        rst_state = 1'b0;
        // Besides reset, only status is honoured while the engine runs
        if (io_out === CODE_STATUS) mode_q = 2'd1;
        else if (!busy) begin
          n_rd = 0;
          mode_q = (io_out === CMD_SIG) ? 2'd2 :
                   (io_out === CMD_READ_SPARE) ? 2'd3 : 2'd0;
        end
      end
    end else if (!ce_n && ale) begin
      if (mode_q == 2'd2 && io_out !== SIG_ADDR) mode_q = 2'd0;
      if (n_adr == 0) col = io_out;
      n_adr++;
    end
  end

  // Read data; a released bus shows the inverse of the last byte
  always @* begin
    case (mode_q)
      2'd1: val = {wp_n, ~busy, 5'h1f, fail_in & ~busy};
      2'd2: val = (n_rd == 0) ? MAKER_ID :
                  (n_rd == 1) ? DEVICE_ID : ~last;
      2'd3: val = (col == MARKER_COL) ? marker_byte : ERASED_BYTE;
      default: val = ERASED_BYTE;
    endcase
    io_in = (!ce_n && !re_n) ? val : ~last;
  end

  // Count finished read strobes
  always @(posedge re_n) begin
    if (!ce_n) begin
      last = val;
      n_rd++;
    end
  end
endmodule // flash_model

/* tb/tb_nand_host.sv */
`timescale 1ns/1ps
module tb_nand_host;
  import nand_host_pkg::*;
  localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
  localparam logic [7:0] DEVID = 8'hc3; // Arbitrary value
  logic        mclk, rst, read, write, fail_in;
  logic [4:0]  address;
  logic [31:0] writedata, readdata, q;
  logic [3:0]  byteenable;
  logic [7:0]  marker_byte, io_out, io_in;
  logic        waitrequest, cle, ale, ce_n, we_n, re_n, wp_n, io_oe, rb;
  int          n_errors, checked, rb_lows, base;

  nand_host #(.DIV_CYCLES(2)) i_dut (.mclk(mclk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .rb(rb));

  flash_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVID)) i_flash (.cle(cle),
    .ale(ale), .ce_n(ce_n), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
    .io_out(io_out), .io_in(io_in), .rb(rb), .fail_in(fail_in),
    .marker_byte(marker_byte));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, busy pulse counter, watchdog
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(negedge rb) rb_lows++;
  initial begin
    #400000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    // The answer edge is the one at which waitrequest stands low
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 200);
    if (n >= 200) chk(32'h0, 32'h1);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  // Start an operation and poll its busy bit
  task automatic run_op(input op_t op);
    int n;
    n = 0;
    bus(1'b1, OFS_CMD, {30'h0, op});
    do begin
      bus(1'b0, OFS_CMD, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 500);
    if (n >= 500) chk(32'h0, 32'h1);
    bus(1'b0, OFS_RESULT, 32'h0);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_unmapped();
    bus(1'b1, 5'h14, 32'hffff_ffff);
    bus(1'b0, 5'h14, 32'h0);
    chk(q, 32'h0);
    $display("unmapped done");
  endtask

  task automatic t_reset();
    base = rb_lows;
    run_op(OP_RESET);
    chk(rb_lows - base, 1);
    chk(i_flash.n_resets, 1);
    run_op(OP_RESET);
    chk(rb_lows - base, 1);
    $display("reset done");
  endtask

  task automatic t_status(input logic f, input logic [8:0] exp);
    fail_in <= f;
    run_op(OP_STATUS);
    chk({23'h0, q[RES_FAIL], q[7:0]}, {23'h0, exp});
    $display("status done");
  endtask

  task automatic t_signature();
    run_op(OP_SIG);
    chk({16'h0, q[23:8]}, {16'h0, DEVID, MAKER});
    $display("signature done");
  endtask

  task automatic t_marker(input logic [7:0] mk, input logic bad);
    marker_byte <= mk;
    bus(1'b1, OFS_ROW, 32'h0);
    run_op(OP_MARK);
    chk({30'h0, q[RES_CHECKED], q[RES_BAD]}, {30'h0, 1'b1, bad});
    $display("marker done");
  endtask

  task automatic t_ecc();
    bus(1'b1, OFS_ECC, 32'h0000_0100);
    bus(1'b1, OFS_ECC, 32'h0000_0001);
    bus(1'b0, OFS_ECC, 32'h0);
    chk(q, 32'h0015_5555);
    $display("ecc done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_errors = 0;
    checked = 0;
    rb_lows = 0;
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'hf;
    fail_in = 1'b0;
    marker_byte = 8'hff;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_unmapped();
    t_reset();
    bus(1'b1, OFS_CFG, 32'h1);
    t_status(1'b0, 9'h040);
    t_signature();
    t_marker(8'hff, 1'b0);
    t_status(1'b0, 9'h0c0);
    t_status(1'b1, 9'h1c1);
    t_marker(8'h00, 1'b1);
    t_ecc();
    report_and_stop();
  end
endmodule // tb_nand_host
